// ### logic/emrf_consts.vh
// Constants for the receive filter and control block of the Ethernet MAC.
`ifndef EMRF_CONSTS_VH
`define EMRF_CONSTS_VH
// ----------------------------------------
// Direct byte register offsets
// ----------------------------------------
`define EMRF_OFS_LOW_THR 9'h15a
`define EMRF_OFS_HIGH_THR 9'h15b
`define EMRF_OFS_IRQ_EN 9'h15c
`define EMRF_OFS_QSTAT 9'h15d
`define EMRF_OFS_REJECT 9'h15e
`define EMRF_OFS_IND_HI 9'h140
`define EMRF_OFS_IND_LO 9'h141
`define EMRF_OFS_IND_D3 9'h142
`define EMRF_OFS_IND_D0 9'h145
`define EMRF_OFS_IND_CMD 9'h146
// ----------------------------------------
// Indirect addresses and reset values
// ----------------------------------------
`define EMRF_IA_MAC_CONTROL 16'h0000
`define EMRF_IA_PHY_MGMT 16'h0014
`define EMRF_MAC_CONTROL_RST 32'h00000000
`define EMRF_PHY_MGMT_RST 32'h00005ac0
`define EMRF_REJECT_RST 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EMRF_B_HB_OFF 28
`define EMRF_B_NO_SELF 23
`define EMRF_B_LOOP 21
`define EMRF_B_FDX 20
`define EMRF_B_ALL 19
`define EMRF_B_ALL_MC 18
`define EMRF_B_LATE_RETRY 12
`define EMRF_B_SINGLE 10
`define EMRF_B_PAD_STRIP 8
`define EMRF_B_DEFER_ABORT 5
`define EMRF_B_TX_ON 3
`define EMRF_B_RX_ON 2
`define EMRF_B_FIFO_OVF 3
`define EMRF_B_QUEUE_OVF 2
`define EMRF_B_HIGH 1
`define EMRF_B_LOW 0
`define EMRF_B_LOW_EN 1
`define EMRF_B_HIGH_EN 0
`define EMRF_B_NONPAUSE 6
`define EMRF_B_CTRL 5
`define EMRF_B_LEN 4
`define EMRF_B_FCS 3
`define EMRF_B_ODD 2
`define EMRF_B_RXERR 1
`define EMRF_B_BCAST 0
// ----------------------------------------
// Timing and frame figures
// ----------------------------------------
`define EMRF_DEFER_BITS 24288
`define EMRF_BITS_PER_NIB 4
`define EMRF_SLOT_BITS 512
`define EMRF_HB_WINDOW_NIB 16
`define EMRF_MAX_TRIES 16
`define EMRF_THR_UNIT_PKTS 32
`define EMRF_MIN_FRAME 64
`define EMRF_MIN_PAYLOAD 46
`define EMRF_MAX_LEN_FIELD 1500
`define EMRF_CTRL_TYPE 16'h8808
`define EMRF_PAUSE_OP 16'h0001
`define EMRF_CRC_RESIDUE 32'hc704dd7b
`endif

// ### logic/emrf_top.v
// Receive filter, queue status and MAC control logic with its receive FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "emrf_consts.vh"
// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module emrf_fifo #(parameter W = 10, parameter D = 8, parameter AW = 3) (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1]; // Flip-flop storage.
	reg [AW-1:0] wp; // Write index.
	reg [AW-1:0] rp; // Read index.
	reg [AW:0] cnt; // Words held.
	wire wr = in_valid & in_ready;
	wire rd = out_valid & out_ready;
	assign in_ready = (cnt != D[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data = mem[rp];
	// Pointers and count move only under the clock enable.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (wr) begin
				wp <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
			end
			if (rd) begin
				rp <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
			end
			cnt <= cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
		end
	end
	// Storage has no reset; reads are guarded by the count.
	always @(posedge ref_clk) begin
		if (ce && wr) begin
			mem[wp] <= in_data;
		end
	end
endmodule
// ----------------------------------------
// Top level
// ----------------------------------------
module emrf_top #(
	parameter [15:0] DEFER_NIB = `EMRF_DEFER_BITS / `EMRF_BITS_PER_NIB,
	parameter [47:0] STATION_ADDR = 48'h02_00_00_00_00_01, // Arbitrary value.
	parameter FIFO_DEPTH = 8
) (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire [8:0] cpu_addr,
	input wire [7:0] cpu_wdata,
	input wire cpu_wr,
	input wire cpu_rd,
	output reg [7:0] cpu_rdata,
	input wire mii_rx_clk,
	input wire mii_tx_clk,
	input wire [3:0] mii_rxd,
	input wire mii_rx_dv,
	input wire mii_rx_er,
	input wire mii_crs,
	input wire mii_col,
	output reg [3:0] mii_txd,
	output wire mii_tx_en,
	input wire tx_req,
	input wire [3:0] tx_nib,
	input wire tx_nib_last,
	output reg tx_nib_take,
	output reg tx_restart,
	output reg tx_done,
	output reg tx_abort,
	output reg hb_fail,
	input wire [15:0] rxq_pkts,
	input wire rxq_overflow,
	output wire rx_out_valid,
	input wire rx_out_ready,
	output wire [7:0] rx_out_data,
	output wire rx_out_eof,
	output wire rx_out_accept,
	output wire irq
);
	localparam [16:0] SLOT_NIB = `EMRF_SLOT_BITS / `EMRF_BITS_PER_NIB;
	localparam [13:0] LATE_NIB = `EMRF_SLOT_BITS / `EMRF_BITS_PER_NIB;
	localparam [1:0] R_IDLE = 2'h0, R_PRE = 2'h1, R_DATA = 2'h2, R_SKIP = 2'h3;
	localparam [2:0] T_IDLE = 3'h0, T_DEFER = 3'h1, T_SEND = 3'h2, T_END = 3'h3;
	localparam [2:0] T_BACK = 3'h4, T_HB = 3'h5;
	// One nibble of CRC-32, data taken least significant bit first.
	function [31:0] crc_nib;
		input [31:0] c;
		input [3:0] d;
		integer i;
		reg [31:0] x;
		begin
			x = c;
			for (i = 0; i < 4; i = i + 1) begin
				x = (x[31] ^ d[i]) ? ({x[30:0], 1'b0} ^ 32'h04c11db7) : {x[30:0], 1'b0};
			end
			crc_nib = x;
		end
	endfunction
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [31:0] mac_control; // Indirect 0000h.
	reg [31:0] phy_mgmt_address; // Indirect 0014h, held only.
	reg [7:0] rx_frame_reject_control;
	reg [7:0] low_thr;
	reg [7:0] high_thr;
	reg [3:0] irq_en;
	reg [3:0] qstat; // Latched queue status.
	reg [15:0] ind_addr;
	reg [31:0] ind_data;
	wire heartbeat_off = mac_control[`EMRF_B_HB_OFF];
	wire no_self_receive = mac_control[`EMRF_B_NO_SELF];
	wire loopback_on = mac_control[`EMRF_B_LOOP];
	wire fdx = mac_control[`EMRF_B_FDX];
	wire accept_all = mac_control[`EMRF_B_ALL];
	wire accept_all_multicast = mac_control[`EMRF_B_ALL_MC];
	wire late_collision_retry = mac_control[`EMRF_B_LATE_RETRY];
	wire single_attempt = mac_control[`EMRF_B_SINGLE];
	wire pad_strip_on = mac_control[`EMRF_B_PAD_STRIP];
	wire [1:0] backoff_limit = mac_control[7:6];
	wire deferral_abort_on = mac_control[`EMRF_B_DEFER_ABORT];
	wire tx_on = mac_control[`EMRF_B_TX_ON];
	wire rx_on = mac_control[`EMRF_B_RX_ON];
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Bits: rx_clk, tx_clk, crs, col, rx_er, rx_dv, rxd[3:0].
	wire [9:0] pins = {mii_rx_clk, mii_tx_clk, mii_crs, mii_col, mii_rx_er, mii_rx_dv, mii_rxd};
	reg [9:0] s1;
	reg [9:0] s2;
	reg [9:0] s3;
	reg [9:0] filt; // Level taken once stages two and three agree.
	reg [9:0] filt_d;
	// Each pin passes three flops; a change counts only when two and three agree.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 10'h000;
			s2 <= 10'h000;
			s3 <= 10'h000;
			filt <= 10'h000;
			filt_d <= 10'h000;
		end else if (ce) begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
			filt <= (s2 & s3) | (filt & (s2 | s3));
			filt_d <= filt;
		end
	end
	wire rx_rise = filt[9] & ~filt_d[9];
	wire tx_tick = filt[8] & ~filt_d[8];
	wire f_crs = filt[7];
	wire f_col = filt[6];
	reg tx_en_i; // Internal transmit enable.
	reg [3:0] txd_i;
	// Loopback feeds the transmit nibbles back and keeps the PHY quiet.
	assign mii_tx_en = tx_en_i & ~loopback_on;
	wire r_tick = loopback_on ? tx_tick : rx_rise;
	wire r_dv = loopback_on ? tx_en_i : filt[4];
	wire [3:0] r_d = loopback_on ? txd_i : filt[3:0];
	wire r_er = ~loopback_on & filt[5];
	// ----------------------------------------
	// Receive parser and filter
	// ----------------------------------------
	reg [1:0] rst_q; // Receive state.
	reg [31:0] crc;
	reg nib_hi;
	reg [3:0] lo_nib;
	reg [13:0] bcnt; // Whole bytes received after the delimiter.
	reg bcast, mcast, uni, saw_er, saw_col;
	reg [15:0] len_type;
	reg [15:0] opcode;
	reg byte_v; // One-cycle push of a data byte.
	reg [7:0] byte_d;
	reg eof_v; // One-cycle push of the end marker.
	reg eof_acc;
	wire [7:0] nb = {r_d, lo_nib};
	wire [7:0] st_byte = STATION_ADDR[47 - 8 * bcnt[2:0] -: 8];
	wire is_ctrl = (len_type == `EMRF_CTRL_TYPE);
	wire is_pause = is_ctrl & (opcode == `EMRF_PAUSE_OP);
	wire [15:0] exp_len = (len_type < `EMRF_MIN_PAYLOAD) ? 16'd46 : len_type;
	wire len_err = (len_type <= `EMRF_MAX_LEN_FIELD) & ({2'b00, bcnt} != exp_len + 16'd18);
	wire fcs_bad = (crc != `EMRF_CRC_RESIDUE);
	wire runt = (bcnt < `EMRF_MIN_FRAME);
	wire [7:0] rj = rx_frame_reject_control;
	wire addr_ok = accept_all | bcast | (mcast & accept_all_multicast) | uni;
	wire accept = addr_ok
		& ~(is_ctrl & ~rj[`EMRF_B_CTRL])
		& ~(is_ctrl & ~is_pause & ~rj[`EMRF_B_NONPAUSE])
		& ~(len_err & ~is_ctrl & ~rj[`EMRF_B_LEN])
		& ~((fcs_bad | saw_er) & ~rj[`EMRF_B_FCS])
		& ~(nib_hi & ~runt & ~saw_col & ~rj[`EMRF_B_ODD])
		& ~(saw_er & ~rj[`EMRF_B_RXERR])
		& ~(bcast & ~rj[`EMRF_B_BCAST]);
	// Short frames stop being stored once the length field's data is in.
	wire strip = pad_strip_on & (bcnt >= 14'd14) & (len_type < `EMRF_MIN_PAYLOAD)
		& ({2'b00, bcnt} >= len_type + 16'd14);
	// One receive step per link clock edge; frames start only when allowed.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_q <= R_IDLE;
			crc <= 32'hffffffff;
			nib_hi <= 1'b0;
			lo_nib <= 4'h0;
			bcnt <= 14'h0000;
			{bcast, mcast, uni, saw_er, saw_col} <= 5'h00;
			len_type <= 16'h0000;
			opcode <= 16'h0000;
			byte_v <= 1'b0;
			byte_d <= 8'h00;
			eof_v <= 1'b0;
			eof_acc <= 1'b0;
		end else if (ce) begin
			byte_v <= 1'b0;
			eof_v <= 1'b0;
			if (r_tick) begin
				case (rst_q)
					R_IDLE: begin
						// With no_self_receive set, own frames are not taken while the transmitter drives, except in loopback.
						if (r_dv && rx_on && !(no_self_receive && tx_en_i && !loopback_on)) begin
							rst_q <= R_PRE;
						end else if (r_dv) begin
							rst_q <= R_SKIP;
						end
					end
					R_SKIP: begin
						if (!r_dv) begin
							rst_q <= R_IDLE;
						end
					end
					R_PRE: begin
						if (!r_dv) begin
							rst_q <= R_IDLE;
						end else if (r_d == 4'hd) begin
							rst_q <= R_DATA;
							crc <= 32'hffffffff;
							nib_hi <= 1'b0;
							bcnt <= 14'h0000;
							{bcast, mcast, uni, saw_er, saw_col} <= 5'h1c;
							len_type <= 16'hffff;
							opcode <= 16'h0000;
						end
					end
					default: begin
						if (r_dv) begin
							crc <= crc_nib(crc, r_d);
							saw_er <= saw_er | r_er;
							saw_col <= saw_col | (f_col & ~fdx);
							nib_hi <= ~nib_hi;
							lo_nib <= r_d;
							if (nib_hi) begin
								bcnt <= bcnt + 14'd1;
								if (bcnt < 14'd6) begin
									bcast <= bcast & (nb == 8'hff);
									uni <= uni & (nb == st_byte);
								end
								if (bcnt == 14'd0) begin
									mcast <= nb[0];
								end
								if (bcnt == 14'd12) begin
									len_type[15:8] <= nb;
								end
								if (bcnt == 14'd13) begin
									len_type[7:0] <= nb;
								end
								if (bcnt == 14'd14) begin
									opcode[15:8] <= nb;
								end
								if (bcnt == 14'd15) begin
									opcode[7:0] <= nb;
								end
								byte_v <= ~strip;
								byte_d <= nb;
							end
						end else begin
							eof_v <= 1'b1;
							eof_acc <= accept;
							rst_q <= R_IDLE;
						end
					end
				endcase
			end
		end
	end
	// The wire cannot wait, so a full FIFO shows as an overflow event.
	wire f_in_valid = byte_v | eof_v;
	wire f_in_ready;
	wire fifo_ovf = f_in_valid & ~f_in_ready;
	emrf_fifo #(.W(10), .D(FIFO_DEPTH), .AW(3)) u_fifo (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data({eof_v, eof_acc & eof_v, byte_d & {8{~eof_v}}}),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready),
		.out_data({rx_out_eof, rx_out_accept, rx_out_data})
	);
	// ----------------------------------------
	// Transmit attempt control
	// ----------------------------------------
	reg [2:0] tst_q;
	reg [15:0] defer_cnt;
	reg [13:0] ncnt;
	reg [4:0] tries;
	reg [16:0] bo_cnt;
	reg [4:0] hb_cnt;
	reg hb_seen;
	reg [9:0] lfsr;
	wire [3:0] lim = (backoff_limit == 2'b00) ? 4'd10 : (backoff_limit == 2'b01) ? 4'd8 :
		(backoff_limit == 2'b10) ? 4'd4 : 4'd1;
	wire [4:0] nt = tries + 5'd1;
	wire [3:0] kbits = (nt > {1'b0, lim}) ? lim : nt[3:0];
	wire [9:0] bo_r = lfsr & ~(10'h3ff << kbits);
	wire col_hd = f_col & ~fdx;
	// Defers, sends, backs off after collisions and checks heartbeat per nibble.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tst_q <= T_IDLE;
			defer_cnt <= 16'h0000;
			ncnt <= 14'h0000;
			tries <= 5'h00;
			bo_cnt <= 17'h00000;
			hb_cnt <= 5'h00;
			hb_seen <= 1'b0;
			lfsr <= 10'h001;
			tx_en_i <= 1'b0;
			txd_i <= 4'h0;
			mii_txd <= 4'h0;
			{tx_nib_take, tx_restart, tx_done, tx_abort, hb_fail} <= 5'h00;
		end else if (ce) begin
			lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
			{tx_nib_take, tx_restart, tx_done, tx_abort, hb_fail} <= 5'h00;
			mii_txd <= txd_i;
			if (tx_tick) begin
				case (tst_q)
					T_IDLE: begin
						ncnt <= 14'h0000;
						if (tx_req && tx_on) begin
							tst_q <= (f_crs && !fdx) ? T_DEFER : T_SEND;
						end
					end
					T_DEFER: begin
						defer_cnt <= defer_cnt + 16'd1;
						if (deferral_abort_on && defer_cnt >= DEFER_NIB) begin
							tx_abort <= 1'b1;
							defer_cnt <= 16'h0000;
							tries <= 5'h00;
							tst_q <= T_IDLE;
						end else if (!f_crs) begin
							tst_q <= T_SEND;
						end
					end
					T_SEND: begin
						if (col_hd && tx_en_i) begin
							tx_en_i <= 1'b0;
							defer_cnt <= 16'h0000;
							tries <= nt;
							if (single_attempt || nt == `EMRF_MAX_TRIES
								|| (ncnt >= LATE_NIB && !late_collision_retry)) begin
								tx_abort <= 1'b1;
								tries <= 5'h00;
								tst_q <= T_IDLE;
							end else begin
								tx_restart <= 1'b1;
								bo_cnt <= {7'h00, bo_r} * SLOT_NIB;
								tst_q <= T_BACK;
							end
						end else begin
							tx_en_i <= 1'b1;
							txd_i <= tx_nib;
							tx_nib_take <= 1'b1;
							ncnt <= ncnt + 14'd1;
							if (tx_nib_last) begin
								tst_q <= T_END;
							end
						end
					end
					T_END: begin
						tx_en_i <= 1'b0;
						tx_done <= 1'b1;
						tries <= 5'h00;
						defer_cnt <= 16'h0000;
						hb_cnt <= 5'h00;
						hb_seen <= 1'b0;
						tst_q <= T_HB;
					end
					T_BACK: begin
						if (bo_cnt == 17'h00000) begin
							tst_q <= T_IDLE;
						end else begin
							bo_cnt <= bo_cnt - 17'd1;
						end
					end
					default: begin
						hb_seen <= hb_seen | f_col;
						hb_cnt <= hb_cnt + 5'd1;
						if (hb_cnt == `EMRF_HB_WINDOW_NIB) begin
							hb_fail <= ~hb_seen & ~fdx & ~heartbeat_off;
							tst_q <= T_IDLE;
						end
					end
				endcase
			end
		end
	end
	// ----------------------------------------
	// Queue watermarks and latched status
	// ----------------------------------------
	reg [15:0] lvl_d;
	wire [15:0] hi_p = {3'b000, high_thr, 5'h00}; // Threshold in packets.
	wire [15:0] lo_p = {3'b000, low_thr, 5'h00};
	wire [3:0] qset = {fifo_ovf, rxq_overflow,
		(lvl_d < hi_p) & (rxq_pkts >= hi_p), (lvl_d >= lo_p) & (rxq_pkts < lo_p)};
	wire rd_hit = cpu_rd & (cpu_addr == `EMRF_OFS_QSTAT);
	wire [31:0] ind_rd = (ind_addr == `EMRF_IA_MAC_CONTROL) ? mac_control :
		(ind_addr == `EMRF_IA_PHY_MGMT) ? phy_mgmt_address : 32'h00000000;
	// Enables for high and low sit in reversed order to the status flags.
	assign irq = |(qstat & {irq_en[3:2], irq_en[`EMRF_B_HIGH_EN], irq_en[`EMRF_B_LOW_EN]});
	// Register writes, reads and read-to-clear; a new event beats the clear.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mac_control <= `EMRF_MAC_CONTROL_RST;
			phy_mgmt_address <= `EMRF_PHY_MGMT_RST;
			rx_frame_reject_control <= `EMRF_REJECT_RST;
			{low_thr, high_thr} <= 16'h0000;
			irq_en <= 4'h0;
			qstat <= 4'h0;
			ind_addr <= 16'h0000;
			ind_data <= 32'h00000000;
			lvl_d <= 16'h0000;
			cpu_rdata <= 8'h00;
		end else if (ce) begin
			lvl_d <= rxq_pkts;
			qstat <= (qstat & {4{~rd_hit}}) | qset;
			if (cpu_wr) begin
				if (cpu_addr == `EMRF_OFS_LOW_THR) begin
					low_thr <= cpu_wdata;
				end else if (cpu_addr == `EMRF_OFS_HIGH_THR) begin
					high_thr <= cpu_wdata;
				end else if (cpu_addr == `EMRF_OFS_IRQ_EN) begin
					irq_en <= cpu_wdata[3:0];
				end else if (cpu_addr == `EMRF_OFS_REJECT) begin
					rx_frame_reject_control <= {1'b0, cpu_wdata[6:0]};
				end else if (cpu_addr == `EMRF_OFS_IND_HI) begin
					ind_addr[15:8] <= cpu_wdata;
				end else if (cpu_addr == `EMRF_OFS_IND_LO) begin
					ind_addr[7:0] <= cpu_wdata;
				end else if (cpu_addr >= `EMRF_OFS_IND_D3 && cpu_addr <= `EMRF_OFS_IND_D0) begin
					ind_data[8 * (3 - (cpu_addr - `EMRF_OFS_IND_D3)) +: 8] <= cpu_wdata;
				end else if (cpu_addr == `EMRF_OFS_IND_CMD && cpu_wdata[1]) begin
					ind_data <= ind_rd;
				end else if (cpu_addr == `EMRF_OFS_IND_CMD && cpu_wdata[0]) begin
					if (ind_addr == `EMRF_IA_MAC_CONTROL) begin
						mac_control <= ind_data;
					end else if (ind_addr == `EMRF_IA_PHY_MGMT) begin
						phy_mgmt_address <= {16'h0000, ind_data[15:6], 6'h00};
					end
				end
			end
			if (cpu_rd) begin
				if (cpu_addr == `EMRF_OFS_LOW_THR) begin
					cpu_rdata <= low_thr;
				end else if (cpu_addr == `EMRF_OFS_HIGH_THR) begin
					cpu_rdata <= high_thr;
				end else if (cpu_addr == `EMRF_OFS_IRQ_EN) begin
					cpu_rdata <= {4'h0, irq_en};
				end else if (cpu_addr == `EMRF_OFS_QSTAT) begin
					cpu_rdata <= {4'h0, qstat};
				end else if (cpu_addr == `EMRF_OFS_REJECT) begin
					cpu_rdata <= rx_frame_reject_control;
				end else if (cpu_addr == `EMRF_OFS_IND_HI) begin
					cpu_rdata <= ind_addr[15:8];
				end else if (cpu_addr == `EMRF_OFS_IND_LO) begin
					cpu_rdata <= ind_addr[7:0];
				end else if (cpu_addr >= `EMRF_OFS_IND_D3 && cpu_addr <= `EMRF_OFS_IND_D0) begin
					cpu_rdata <= ind_data[8 * (3 - (cpu_addr - `EMRF_OFS_IND_D3)) +: 8];
				end else begin
					cpu_rdata <= 8'h00;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/emrf_phy_model.sv
// Behavioural PHY that plays receive frames into the MII pins.
`timescale 1ns/100ps
`default_nettype none
module emrf_phy_model (
	output logic mii_rx_clk,
	output logic mii_tx_clk,
	output logic [3:0] mii_rxd,
	output logic mii_rx_dv,
	output logic mii_rx_er,
	output logic mii_crs
);
	// ----------------------------------------
	// Pins
	// ----------------------------------------
	// The clock only runs while a frame is played; it starts low and stops high after each frame.
	initial begin
		mii_rx_clk = 1'b0;
		mii_rxd = 4'h0;
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
		mii_crs = 1'b0;
	end
	// The transmit clock follows the receive clock; nothing is sent here.
	assign mii_tx_clk = mii_rx_clk;
	// One 160 ns nibble period; data changes while the clock is low.
	task automatic tick(input logic [3:0] v);
		mii_rx_clk = 1'b0;
		mii_rxd = v;
		#80 mii_rx_clk = 1'b1;
		#80;
	endtask
	// Plays a 64-byte frame: 0 broadcast, 1 pause, 2 other control, 3 broadcast with a line error.
	task automatic send(input int kind);
		logic [127:0] h;
		logic [7:0] b;
		h = {kind == 1 || kind == 2 ? 48'h0180c2000001 : 48'hffffffffffff, 48'h021122334455,
			kind == 1 || kind == 2 ? 16'h8808 : 16'h0800, 8'h00, kind == 2 ? 8'h02 : 8'h01};
		mii_rx_dv = 1'b1;
		mii_crs = 1'b1;
		for (int n = 0; n < 144; n++) begin
			b = (n >= 16 && n < 48) ? h[127 - 8 * ((n - 16) / 2) -: 8] : 8'h00;
			mii_rx_er = kind == 3 && n == 40;
			tick(n < 15 ? 4'h5 : n == 15 ? 4'hd : n[0] ? b[7:4] : b[3:0]);
		end
		mii_rx_dv = 1'b0;
		mii_crs = 1'b0;
		// A released data line must not keep its last value.
		repeat (4) tick(~mii_rxd);
	endtask
endmodule
`default_nettype wire

// ### sim/emrf_top_monitor.sv
// Port-level assertions for the receive filter and control block.
`timescale 1ns/100ps
`default_nettype none
`include "emrf_consts.vh"
module emrf_monitor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [8:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_rdata,
	input wire logic [15:0] rxq_pkts,
	input wire logic rxq_overflow,
	input wire logic rx_out_valid,
	input wire logic rx_out_ready,
	input wire logic [7:0] rx_out_data,
	input wire logic rx_out_eof,
	input wire logic mii_tx_en,
	input wire logic tx_nib_take,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// A read of the latched queue status.
	wire qrd = cpu_rd && cpu_addr == `EMRF_OFS_QSTAT;
	// Set by the first indirect command; until then the MAC is still disabled.
	logic cmd_seen;
	// Tracks the first indirect command.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			cmd_seen <= 1'b0;
		else if (cpu_wr && cpu_addr == `EMRF_OFS_IND_CMD)
			cmd_seen <= 1'b1;
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata)) else $error("read data moved");
	unmapped_zero_a: assert property (cpu_rd && cpu_addr == 9'h1ff |=> cpu_rdata == 8'h00) else $error("bad read");
	qovf_latch_a: assert property (rxq_overflow ##2 qrd |=> cpu_rdata[2]) else $error("overflow lost");
	qstat_clear_a: assert property (qrd && !rxq_overflow ##1 !cpu_rd && !rxq_overflow ##1 qrd && !rxq_overflow
		|=> !cpu_rdata[2]) else $error("status not cleared");
	irq_clear_a: assert property (qrd && !rxq_overflow && !rx_out_valid && $stable(rxq_pkts)
		&& $past(rxq_pkts) == $past(rxq_pkts, 2) |=> !irq) else $error("irq stuck");
	fifo_hold_a: assert property (rx_out_valid && !rx_out_ready
		|=> rx_out_valid && $stable(rx_out_data) && $stable(rx_out_eof)) else $error("word dropped");
	idle_mac_a: assert property (!cmd_seen |-> !mii_tx_en && !tx_nib_take && !rx_out_valid) else $error("mac on");
	qstat_upper_a: assert property (qrd |=> cpu_rdata[7:4] == 4'h0) else $error("status high bits");
endmodule
bind emrf_top emrf_monitor u_mon (.*);
`default_nettype wire

// ### sim/emrf_top_test.sv
// Self-checking bench for the receive filter and control block.
`timescale 1ns/100ps
`default_nettype none
`include "emrf_consts.vh"
module emrf_top_test;
	// Bench-driven inputs of the block.
	logic ref_clk = 1'b0, arst_n = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, rxq_overflow = 1'b0, rx_out_ready = 1'b1;
	logic ce = 1'b1, mii_col = 1'b0;
	logic [8:0] cpu_addr = 9'h000;
	logic [7:0] cpu_wdata = 8'h00, rd_val, acc, first;
	logic [15:0] rxq_pkts = 16'h0000;
	logic [31:0] word;
	wire [7:0] cpu_rdata, rx_out_data;
	wire [3:0] mii_rxd, mii_txd;
	wire mii_rx_clk, mii_tx_clk, mii_rx_dv, mii_rx_er, mii_crs, mii_tx_en, rx_out_valid, rx_out_eof, rx_out_accept;
	wire irq, tx_nib_take, tx_restart, tx_done, tx_abort, hb_fail;
	int failures = 0, comparisons = 0, eofs = 0, k, nbytes = 0, got_bytes = 0;
	// Register rows: address, value written, value read back.
	logic [27:0] regs [5] = '{28'h15eff7f, 28'h15c0f0f, 28'h15a0101, 28'h15b0202, 28'h1ff5a00};
	// Frame rows: filter setting, frame kind, expected accept flag.
	logic [15:0] fr [7] = '{16'h1e00, 16'h1f01, 16'h1f10, 16'h3f11, 16'h3f20, 16'h7f21, 16'h1f31};
	// ----------------------------------------
	// Clock, design and partner
	// ----------------------------------------
	always #5 ref_clk = ~ref_clk;
	// The transmit source stays idle, so its inputs are tied; the clock enable is driven.
	emrf_top #(.DEFER_NIB(16'd20)) DUT (.*, .tx_req(1'b0), .tx_nib(4'h0), .tx_nib_last(1'b0));
	emrf_phy_model PHY (.*);
	// Records the accept flag, byte count and first byte of each frame taken from the FIFO.
	always @(posedge ref_clk) begin
		if (rx_out_valid && rx_out_ready && rx_out_eof) begin
			eofs <= eofs + 1;
			acc <= {7'h00, rx_out_accept};
			got_bytes <= nbytes;
			nbytes <= 0;
		end else if (rx_out_valid && rx_out_ready) begin
			if (nbytes == 0)
				first <= rx_out_data;
			nbytes <= nbytes + 1;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("Error at %0t: expected %h, got %h", $time, exp, got);
			failures++;
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge ref_clk);
		cpu_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [8:0] a);
		@(posedge ref_clk);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge ref_clk);
		cpu_rd <= 1'b0;
		#1 rd_val = cpu_rdata;
	endtask
	// Indirect access to mac_control: 1 writes word, 2 reads it back into word.
	task automatic ind(input logic [7:0] cmd);
		wr(`EMRF_OFS_IND_HI, 8'h00);
		wr(`EMRF_OFS_IND_LO, 8'h00);
		for (int i = 0; i < 4; i++)
			if (cmd == 8'h01) wr(`EMRF_OFS_IND_D3 + 9'(i), word[31 - 8 * i -: 8]);
		wr(`EMRF_OFS_IND_CMD, cmd);
		for (int i = 0; i < 4; i++) begin
			if (cmd == 8'h02) begin
				rd(`EMRF_OFS_IND_D3 + 9'(i));
				word[31 - 8 * i -: 8] = rd_val;
			end
		end
	endtask
	task automatic pulse();
		@(posedge ref_clk) rxq_overflow <= 1'b1;
		@(posedge ref_clk) rxq_overflow <= 1'b0;
		// Let the latched flag settle before irq is looked at.
		#1;
	endtask
	// Plays one frame and compares the accept flag of its end word.
	task automatic frame(input int kind, input logic [7:0] exp);
		int e0;
		e0 = eofs;
		PHY.send(kind);
		for (k = 0; k < 300 && eofs == e0; k++) @(posedge ref_clk);
		if (eofs == e0) begin
			failures++;
			final_report();
		end else begin
			chk(exp, acc);
			chk(64, got_bytes);
			chk((kind == 1 || kind == 2) ? 8'h01 : 8'hff, first);
		end
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(`EMRF_OFS_REJECT);
		chk(8'h00, rd_val);
		ind(8'h02);
		chk(32'h0, word);
		for (int r = 0; r < 5; r++) begin
			wr(regs[r][24:16], regs[r][15:8]);
			rd(regs[r][24:16]);
			chk(regs[r][7:0], rd_val);
		end
		word = 32'h0004154c;
		ind(8'h01);
		word = 32'h0;
		ind(8'h02);
		chk(32'h0004154c, word);
		// Threshold writes may have latched a crossing, so start clean.
		rd(`EMRF_OFS_QSTAT);
		chk(1'b0, irq);
		pulse();
		chk(1'b1, irq);
		rd(`EMRF_OFS_QSTAT);
		chk(8'h04, rd_val);
		rd(`EMRF_OFS_QSTAT);
		chk(8'h00, rd_val);
		wr(`EMRF_OFS_IRQ_EN, 8'h0b);
		pulse();
		chk(1'b0, irq);
		rd(`EMRF_OFS_QSTAT);
		wr(`EMRF_OFS_IRQ_EN, 8'h01);
		@(posedge ref_clk) rxq_pkts <= 16'd64;
		repeat (4) @(posedge ref_clk);
		chk(1'b1, irq);
		wr(`EMRF_OFS_IRQ_EN, 8'h02);
		chk(1'b0, irq);
		rd(`EMRF_OFS_QSTAT);
		chk(8'h02, rd_val);
		@(posedge ref_clk) rxq_pkts <= 16'd0;
		repeat (4) @(posedge ref_clk);
		rd(`EMRF_OFS_QSTAT);
		chk(8'h01, rd_val);
		for (int r = 0; r < 7; r++) begin
			wr(`EMRF_OFS_REJECT, fr[r][15:8]);
			frame(fr[r][7:4], fr[r][3:0]);
		end
		// Stall the consumer so the eight-word FIFO fills and refuses.
		@(posedge ref_clk) rx_out_ready <= 1'b0;
		PHY.send(0);
		repeat (8) @(posedge ref_clk);
		rd(`EMRF_OFS_QSTAT);
		chk(8'h08, rd_val);
		@(posedge ref_clk) rx_out_ready <= 1'b1;
		for (k = 0; k < 50 && rx_out_valid; k++) @(posedge ref_clk);
		chk(1'b0, rx_out_valid);
		chk(9'h000, {mii_txd, mii_tx_en, tx_done, tx_abort, tx_restart, hb_fail});
		// A write while the clock enable is low must leave the register alone.
		ce <= 1'b0;
		wr(`EMRF_OFS_REJECT, 8'h55);
		@(posedge ref_clk) ce <= 1'b1;
		rd(`EMRF_OFS_REJECT);
		chk(8'h1f, rd_val);
		@(posedge ref_clk) arst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(2'b00, {rx_out_valid, irq});
		arst_n <= 1'b1;
		rd(`EMRF_OFS_REJECT);
		chk(8'h00, rd_val);
		final_report();
	end
endmodule
`default_nettype wire
